// >>> buck_load_current_readout.sv
// Load-current measurement control and result registers.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Bit 0 of the select register picks the first converter at 0 and the second at 1.
// - Each write to the select register starts a fresh measurement on the chosen converter.
// - A selected converter that is master in two-phase use reports master plus slave current.
// - A selected converter that is slave reports only its own current.
// - Result bit 8 reads in bit 0 of the high-bit register at 20 mA per step.
// - Result bits 7 to 0 read in the low-byte register at the same scaling.
module buck_load_current_readout #(
	parameter int SAMPLE_DIV = buck_load_current_pkg::SAMPLE_DIV_CYCLES,
	parameter int AVG_LOG2 = buck_load_current_pkg::AVG_LOG2_DEFAULT
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr_en,
	input wire logic [7:0] reg_wr_data,
	input wire logic reg_rd_en,
	output logic [7:0] reg_rd_data,
	input wire logic [8:0] first_step_down_converter_current,
	input wire logic [8:0] second_step_down_converter_current,
	input wire logic dual_phase,
	input wire logic second_is_master,
	output logic meas_busy
);

	localparam int DIV_W = (SAMPLE_DIV > 1) ? $clog2(SAMPLE_DIV) : 1;
	localparam int RW = buck_load_current_pkg::RESULT_WIDTH;
	localparam int MEAS_MAX = (1 << AVG_LOG2) * SAMPLE_DIV + 4;

	buck_load_current_pkg::meas_state_t state_q;
	buck_load_current_pkg::meas_state_t state_d;
	logic [7:0] sel_q;
	logic [7:0] sel_d;
	logic [RW-1:0] result_q;
	logic [RW-1:0] result_d;
	logic [7:0] rd_data_q;
	logic [7:0] rd_data_d;
	logic busy_q;
	logic busy_d;
	logic [DIV_W-1:0] div_q;
	logic [DIV_W-1:0] div_d;
	logic wr_sel;
	logic sel_conv;
	logic sel_is_master;
	logic tick;
	logic sample_en;
	logic [RW:0] sum_w;
	logic [RW-1:0] sample_mux;
	logic acc_done;
	logic [RW-1:0] acc_avg;

	////////////////////////////////////////////////////////////////////////
	// Source selection

	assign wr_sel = reg_wr_en &&
		(reg_addr == buck_load_current_pkg::ADDR_LOAD_MEASURE_SELECT);
	assign sel_conv = sel_q[buck_load_current_pkg::SEL_CONVERTER_BIT];
	assign sel_is_master = dual_phase && (sel_conv == second_is_master);
	assign sum_w = {1'b0, first_step_down_converter_current} +
		{1'b0, second_step_down_converter_current};

	// Pick the sample fed to the averager; the summed pair saturates.
	always_comb begin
		sample_mux = first_step_down_converter_current;
		if (sel_is_master) begin
			sample_mux = sum_w[RW] ?
				buck_load_current_pkg::FULL_SCALE_CODE : sum_w[RW-1:0];
		end else if (sel_conv ==
			buck_load_current_pkg::SEL_SECOND_STEP_DOWN_CONVERTER) begin
			// slave reports only its own current.
			sample_mux = second_step_down_converter_current;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sequencer, sample divider and registers

	assign tick = (div_q == DIV_W'(SAMPLE_DIV - 1));
	assign sample_en = tick && !wr_sel &&
		(state_q == buck_load_current_pkg::ST_RUN);

	// Next values of control state, result and read data.
	always_comb begin
		state_d = state_q;
		sel_d = sel_q;
		result_d = result_q;
		rd_data_d = rd_data_q;
		div_d = tick ? '0 : div_q + 1'b1;
		// result holds until a measurement completes.
		if (acc_done && (state_q == buck_load_current_pkg::ST_RUN)) begin
			result_d = acc_avg;
			state_d = buck_load_current_pkg::ST_IDLE;
		end
		// a write restarts the window on the new selection.
		if (wr_sel) begin
			sel_d = reg_wr_data;
			state_d = buck_load_current_pkg::ST_RUN;
			div_d = '0;
		end
		busy_d = (state_d == buck_load_current_pkg::ST_RUN);
		if (reg_rd_en) begin
			case (reg_addr)
				buck_load_current_pkg::ADDR_LOAD_MEASURE_SELECT: begin
					rd_data_d = sel_q;
				end
				buck_load_current_pkg::ADDR_LOAD_CURRENT_HIGH_BIT: begin
					rd_data_d = {7'h00,
						result_q[buck_load_current_pkg::RESULT_MSB_BIT]};
				end
				// low byte in bits 7 to 0.
				buck_load_current_pkg::ADDR_LOAD_CURRENT_LOW_BYTE: begin
					rd_data_d = result_q[7:0];
				end
				default: begin
					rd_data_d = buck_load_current_pkg::RST_READ_DATA;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			state_q <= buck_load_current_pkg::ST_IDLE;
			sel_q <= buck_load_current_pkg::RST_LOAD_MEASURE_SELECT;
			result_q <= buck_load_current_pkg::RST_LOAD_CURRENT;
			rd_data_q <= buck_load_current_pkg::RST_READ_DATA;
			busy_q <= 1'b0;
			div_q <= '0;
		end else begin
			state_q <= state_d;
			sel_q <= sel_d;
			result_q <= result_d;
			rd_data_q <= rd_data_d;
			busy_q <= busy_d;
			div_q <= div_d;
		end
	end

	// Averaging of the selected current over the window.
	load_current_averager #(
		.WIDTH(RW),
		.LOG2N(AVG_LOG2)
	) u_averager (
		.clk_sys(clk_sys),
		.reset(reset),
		.clear(wr_sel),
		.sample_en(sample_en),
		.sample_in(sample_mux),
		.done(acc_done),
		.avg(acc_avg)
	);

	assign reg_rd_data = rd_data_q;
	assign meas_busy = busy_q;

	////////////////////////////////////////////////////////////////////////
	// Assertions

	property p_sel_first;
		@(posedge clk_sys) disable iff (reset)
		(wr_sel && !reg_wr_data[0]) |=> (sel_conv == 1'b0) && busy_q;
	endproperty
	a_sel_first: assert property (p_sel_first)
		else $error("Select bit 0 did not choose the first converter.");

	property p_sel_second_single;
		@(posedge clk_sys) disable iff (reset)
		(state_q == buck_load_current_pkg::ST_RUN && !dual_phase && sel_conv)
		|-> sample_mux == second_step_down_converter_current;
	endproperty
	a_sel_second_single: assert property (p_sel_second_single)
		else $error("Select bit 1 did not measure the second converter.");

	property p_write_starts;
		@(posedge clk_sys) disable iff (reset)
		wr_sel |=> busy_q && (state_q == buck_load_current_pkg::ST_RUN)
			&& (sel_q == $past(reg_wr_data));
	endproperty
	a_write_starts: assert property (p_write_starts)
		else $error("Select write did not start a measurement.");

	property p_meas_ends;
		@(posedge clk_sys) disable iff (reset)
		wr_sel |-> ##[1:MEAS_MAX] (acc_done || wr_sel);
	endproperty
	a_meas_ends: assert property (p_meas_ends)
		else $error("Measurement did not complete in time.");

	property p_master_sum;
		@(posedge clk_sys) disable iff (reset)
		(sel_is_master && !sum_w[RW]) |-> sample_mux ==
			first_step_down_converter_current
			+ second_step_down_converter_current;
	endproperty
	a_master_sum: assert property (p_master_sum)
		else $error("Master selection did not report the pair sum.");

	property p_slave_own;
		@(posedge clk_sys) disable iff (reset)
		(dual_phase && !sel_is_master && !sel_conv) |->
			sample_mux == first_step_down_converter_current;
	endproperty
	a_slave_own: assert property (p_slave_own)
		else $error("Slave selection included the master current.");

	property p_read_high;
		@(posedge clk_sys) disable iff (reset)
		(reg_rd_en && reg_addr ==
			buck_load_current_pkg::ADDR_LOAD_CURRENT_HIGH_BIT)
		|=> reg_rd_data == {7'h00, $past(result_q[8])};
	endproperty
	a_read_high: assert property (p_read_high)
		else $error("High-bit register read back wrong.");

	property p_read_low;
		@(posedge clk_sys) disable iff (reset)
		(reg_rd_en && reg_addr ==
			buck_load_current_pkg::ADDR_LOAD_CURRENT_LOW_BYTE)
		|=> reg_rd_data == $past(result_q[7:0]);
	endproperty
	a_read_low: assert property (p_read_low)
		else $error("Low-byte register read back wrong.");

	property p_result_hold;
		@(posedge clk_sys) disable iff (reset)
		!(acc_done && state_q == buck_load_current_pkg::ST_RUN)
		|=> $stable(result_q);
	endproperty
	a_result_hold: assert property (p_result_hold)
		else $error("Result changed without a completed measurement.");

	property p_result_load;
		@(posedge clk_sys) disable iff (reset)
		(acc_done && state_q == buck_load_current_pkg::ST_RUN)
		|=> result_q == $past(acc_avg) && !busy_q || $past(wr_sel);
	endproperty
	a_result_load: assert property (p_result_load)
		else $error("Completed measurement was not stored.");

	c_meas_done: cover property (@(posedge clk_sys) disable iff (reset)
		busy_q ##1 !busy_q);
	c_master: cover property (@(posedge clk_sys) disable iff (reset)
		sel_is_master && acc_done);
	c_read_high: cover property (@(posedge clk_sys) disable iff (reset)
		reg_rd_en && reg_addr ==
		buck_load_current_pkg::ADDR_LOAD_CURRENT_HIGH_BIT && result_q[8]);

endmodule // buck_load_current_readout
`default_nettype wire

// >>> buck_load_current_pkg.sv
// Constants, register map and state encodings of the load-current readout.
`default_nettype none
package buck_load_current_pkg;

	// Register offsets on the internal register port.
	localparam logic [7:0] ADDR_LOAD_MEASURE_SELECT = 8'h24;
	localparam logic [7:0] ADDR_LOAD_CURRENT_HIGH_BIT = 8'h25;
	localparam logic [7:0] ADDR_LOAD_CURRENT_LOW_BYTE = 8'h26;

	// Reset values of the registers.
	localparam logic [7:0] RST_LOAD_MEASURE_SELECT = 8'h00;
	localparam logic [8:0] RST_LOAD_CURRENT = 9'h000;
	localparam logic [7:0] RST_READ_DATA = 8'h00;

	// Field positions.
	localparam int SEL_CONVERTER_BIT = 0;
	localparam int RESULT_MSB_BIT = 8;
	localparam int RESULT_WIDTH = 9;

	// Selector codes of the converter-select bit.
	localparam logic SEL_FIRST_STEP_DOWN_CONVERTER = 1'b0;
	localparam logic SEL_SECOND_STEP_DOWN_CONVERTER = 1'b1;

	// Largest code, 511 steps of 20 mA give 10.22 A.
	localparam logic [8:0] FULL_SCALE_CODE = 9'h1ff;
	localparam int LSB_MILLIAMP = 20;

	// Sampling period of the averaging window.
	localparam int CLK_PERIOD_NS = 40;
	localparam int SAMPLE_PERIOD_NS = 1000;
	localparam int SAMPLE_DIV_CYCLES =
		(SAMPLE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Number of samples averaged is two to this power.
	localparam int AVG_LOG2_DEFAULT = 3;

	// Measurement sequencer states, one-hot.
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_RUN = 2'b10
	} meas_state_t;

endpackage
`default_nettype wire

// >>> load_current_averager.sv
// Averager that sums a power-of-two number of current samples.
`timescale 1ns/1ps
`default_nettype none
module load_current_averager #(
	parameter int WIDTH = 9,
	parameter int LOG2N = 3
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic clear,
	input wire logic sample_en,
	input wire logic [WIDTH-1:0] sample_in,
	output logic done,
	output logic [WIDTH-1:0] avg
);

	localparam int ACC_W = WIDTH + LOG2N;

	logic [ACC_W-1:0] acc_q;
	logic [ACC_W-1:0] acc_d;
	logic [ACC_W-1:0] sum_w;
	logic [LOG2N-1:0] cnt_q;
	logic [LOG2N-1:0] cnt_d;
	logic done_q;
	logic done_d;
	logic [WIDTH-1:0] avg_q;
	logic [WIDTH-1:0] avg_d;

	assign sum_w = acc_q + {{LOG2N{1'b0}}, sample_in};

	// Accumulate samples and divide by shifting after the last one.
	always_comb begin
		acc_d = acc_q;
		cnt_d = cnt_q;
		done_d = 1'b0;
		avg_d = avg_q;
		if (clear) begin
			acc_d = '0;
			cnt_d = '0;
		end else if (sample_en) begin
			if (cnt_q == {LOG2N{1'b1}}) begin
				avg_d = sum_w[ACC_W-1:LOG2N];
				done_d = 1'b1;
				acc_d = '0;
				cnt_d = '0;
			end else begin
				acc_d = sum_w;
				cnt_d = cnt_q + 1'b1;
			end
		end
	end

	// State registers.
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			acc_q <= '0;
			cnt_q <= '0;
			done_q <= 1'b0;
			avg_q <= '0;
		end else begin
			acc_q <= acc_d;
			cnt_q <= cnt_d;
			done_q <= done_d;
			avg_q <= avg_d;
		end
	end

	assign done = done_q;
	assign avg = avg_q;

endmodule // load_current_averager
`default_nettype wire

// >>> buck_load_current_readout_tb.sv
// Self-checking testbench of the load-current readout block.
`timescale 1ns/1ps
`default_nettype none
module buck_load_current_readout_tb;
	logic clk_sys;
	logic reset;
	logic [7:0] reg_addr;
	logic reg_wr_en;
	logic [7:0] reg_wr_data;
	logic reg_rd_en;
	logic [7:0] reg_rd_data;
	logic [8:0] first_step_down_converter_current;
	logic [8:0] second_step_down_converter_current;
	logic dual_phase;
	logic second_is_master;
	logic meas_busy;
	logic [7:0] rd_val;
	int fails;
	int comparisons;
	int cycles;

	////////////////////////////////////////////////////////////////////////
	// Small counts keep each measurement to a handful of cycles.
	buck_load_current_readout #(
		.SAMPLE_DIV(2),
		.AVG_LOG2(1)
	) u_buck_load_current_readout (
		.clk_sys(clk_sys),
		.reset(reset),
		.reg_addr(reg_addr),
		.reg_wr_en(reg_wr_en),
		.reg_wr_data(reg_wr_data),
		.reg_rd_en(reg_rd_en),
		.reg_rd_data(reg_rd_data),
		.first_step_down_converter_current(first_step_down_converter_current),
		.second_step_down_converter_current(second_step_down_converter_current),
		.dual_phase(dual_phase),
		.second_is_master(second_is_master),
		.meas_busy(meas_busy)
	);

	// Clock of 40 ns period.
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	// Cuts a hung run short well past the expected two hundred or fewer cycles.
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 3000) begin
			fails++;
			close_out();
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Prints the verdict and ends the run.
	task automatic close_out();
		if (fails == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Compares one byte and reports a difference at once.
	task automatic check(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One write strobe, held for exactly one sampling edge.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wr_data <= d;
		reg_wr_en <= 1'b1;
		@(posedge clk_sys);
		reg_wr_en <= 1'b0;
	endtask

	// One read strobe; data is taken once the registered answer settles.
	task automatic rd(input logic [7:0] a);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd_en <= 1'b1;
		@(posedge clk_sys);
		reg_rd_en <= 1'b0;
		@(negedge clk_sys);
		rd_val = reg_rd_data;
	endtask

	// Applies converter levels that stay put through a measurement.
	task automatic set_in(input logic dp, input logic sm, input logic [8:0] a,
		input logic [8:0] b);
		@(posedge clk_sys);
		dual_phase <= dp;
		second_is_master <= sm;
		first_step_down_converter_current <= a;
		second_step_down_converter_current <= b;
	endtask

	// Starts a measurement, waits for it, then checks both result bytes.
	task automatic measure(input logic [7:0] sel, input logic [8:0] exp);
		int n;
		wr(buck_load_current_pkg::ADDR_LOAD_MEASURE_SELECT, sel);
		@(negedge clk_sys);
		check("busy after select write", 8'h01, {7'h00, meas_busy});
		n = 0;
		while (meas_busy !== 1'b0 && n < 100) begin
			@(negedge clk_sys);
			n++;
		end
		check("busy cleared", 8'h00, {7'h00, meas_busy});
		rd(buck_load_current_pkg::ADDR_LOAD_MEASURE_SELECT);
		check("select readback", sel, rd_val);
		rd(buck_load_current_pkg::ADDR_LOAD_CURRENT_HIGH_BIT);
		check("result high bit", {7'h00, exp[8]}, rd_val);
		rd(buck_load_current_pkg::ADDR_LOAD_CURRENT_LOW_BYTE);
		check("result low byte", exp[7:0], rd_val);
	endtask

	////////////////////////////////////////////////////////////////////////
	// All three mapped registers read zero after reset.
	task automatic s_reset_values();
		rd(buck_load_current_pkg::ADDR_LOAD_MEASURE_SELECT);
		check("select at reset", 8'h00, rd_val);
		rd(buck_load_current_pkg::ADDR_LOAD_CURRENT_HIGH_BIT);
		check("high bit at reset", 8'h00, rd_val);
		rd(buck_load_current_pkg::ADDR_LOAD_CURRENT_LOW_BYTE);
		check("low byte at reset", 8'h00, rd_val);
	endtask

	// Single-phase selection of each converter, with reserved bits set on the second.
	task automatic s_single_phase();
		set_in(1'b0, 1'b0, 9'h0a5, 9'h1c3);
		measure(8'h00, 9'h0a5);
		measure(8'ha7, 9'h1c3);
	endtask

	// Master reports the sum, slave only its own share, both pairings.
	task automatic s_dual_phase();
		set_in(1'b1, 1'b1, 9'h050, 9'h100);
		measure(8'h01, 9'h150);
		measure(8'h00, 9'h050);
		set_in(1'b1, 1'b0, 9'h050, 9'h100);
		measure(8'h00, 9'h150);
		measure(8'h01, 9'h100);
		set_in(1'b1, 1'b0, 9'h1f0, 9'h020);
		measure(8'h00, 9'h1ff);
	endtask

	// Writes to read-only and unmapped places change nothing.
	task automatic s_refused();
		wr(buck_load_current_pkg::ADDR_LOAD_CURRENT_HIGH_BIT, 8'hff);
		wr(buck_load_current_pkg::ADDR_LOAD_CURRENT_LOW_BYTE, 8'h00);
		wr(8'h30, 8'hff);
		// Look once the edge that took the last write has settled.
		@(negedge clk_sys);
		check("busy after ignored writes", 8'h00, {7'h00, meas_busy});
		rd(8'h30);
		check("unmapped read", 8'h00, rd_val);
		rd(buck_load_current_pkg::ADDR_LOAD_CURRENT_HIGH_BIT);
		check("high bit held", 8'h01, rd_val);
		rd(buck_load_current_pkg::ADDR_LOAD_CURRENT_LOW_BYTE);
		check("low byte held", 8'hff, rd_val);
	endtask

	// A second select write aborts the first and measures the new choice.
	task automatic s_restart();
		set_in(1'b0, 1'b0, 9'h011, 9'h0e2);
		wr(buck_load_current_pkg::ADDR_LOAD_MEASURE_SELECT, 8'h00);
		measure(8'h01, 9'h0e2);
	endtask

	// A reset in mid-measurement clears busy, selection and result.
	task automatic s_mid_reset();
		set_in(1'b0, 1'b0, 9'h011, 9'h0e2);
		wr(buck_load_current_pkg::ADDR_LOAD_MEASURE_SELECT, 8'h01);
		@(posedge clk_sys);
		reset <= 1'b1;
		repeat (2) @(posedge clk_sys);
		reset <= 1'b0;
		@(negedge clk_sys);
		check("busy after reset", 8'h00, {7'h00, meas_busy});
		rd(buck_load_current_pkg::ADDR_LOAD_MEASURE_SELECT);
		check("select after reset", 8'h00, rd_val);
		rd(buck_load_current_pkg::ADDR_LOAD_CURRENT_LOW_BYTE);
		check("low byte after reset", 8'h00, rd_val);
		measure(8'h00, 9'h011);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial begin
		fails = 0;
		comparisons = 0;
		cycles = 0;
		reset = 1'b1;
		reg_addr = 8'h00;
		reg_wr_en = 1'b0;
		reg_wr_data = 8'h00;
		reg_rd_en = 1'b0;
		first_step_down_converter_current = 9'h000;
		second_step_down_converter_current = 9'h000;
		dual_phase = 1'b0;
		second_is_master = 1'b0;
		repeat (6) @(posedge clk_sys);
		reset <= 1'b0;
		s_reset_values();
		s_single_phase();
		s_dual_phase();
		s_refused();
		s_restart();
		s_mid_reset();
		close_out();
	end
endmodule // buck_load_current_readout_tb
`default_nettype wire
